//--- common/ecdm_pkg.sv
// Package with register map, field layout and constants of the duty modulator.
package ecdm_pkg;
  // ****************************************************************
  // Widths and counts.
  // ****************************************************************
  localparam int ADDR_W = 15;
  localparam int IDX_W = 13;
  localparam int DATA_W = 32;
  localparam int BYTE_W = 8;
  localparam int CNT_W = 28;
  localparam int STEP_W = 16;
  localparam int SHOT_W = 3;
  localparam int FB_DELAY_W = 2;
  localparam int CNT_TOP_W = 4;
  localparam int NUM_CNT = 3;
  localparam int NUM_DIV = 2;
  // ****************************************************************
  // Register indices; byte address is four times the index.
  // ****************************************************************
  localparam logic [IDX_W-1:0] IDX_STEP_LO = 13'h10C0;
  localparam logic [IDX_W-1:0] IDX_STEP_HI = 13'h10C1;
  localparam logic [IDX_W-1:0] IDX_CNT_FIRST = 13'h10C2;
  localparam logic [IDX_W-1:0] IDX_CNT_LAST = 13'h10CD;
  localparam logic [IDX_W-1:0] IDX_DIVIDER_C_EVENT_COUNT_TOP = 13'h10CD;
  localparam logic [IDX_W-1:0] IDX_FEEDBACK_SYNC_EDGE_DELAY = 13'h10CE;
  localparam logic [IDX_W-1:0] IDX_DIVIDER_A_MODULATOR_SETTINGS = 13'h10CF;
  localparam logic [IDX_W-1:0] IDX_DIVIDER_B_MODULATOR_SETTINGS = 13'h10D0;
  localparam logic [IDX_W-1:0] IDX_BURST_REQUEST_MODE = 13'h10D3;
  localparam logic [IDX_W-1:0] IDX_MODULATOR_STATUS = 13'h10E0;
  // ****************************************************************
  // Field positions and reset values.
  // ****************************************************************
  localparam int SET_EN_BIT = 0;
  localparam int SET_POL_BIT = 1;
  localparam int SET_SINGLE_BIT = 2;
  localparam int SET_BURST_BIT = 3;
  localparam int SET_W = 4;
  localparam int REQ_MODE_BIT = 6;
  localparam int ST_VALID_LSB = 0;
  localparam int ST_MOD_ON_BIT = 2;
  localparam int ST_REQ_BIT = 3;
  localparam int ST_SHOTS_A_LSB = 4;
  localparam int ST_SHOTS_B_LSB = 8;
  localparam int CNT_BYTE_SEL_W = 2;
  localparam logic [CNT_BYTE_SEL_W-1:0] CNT_TOP_BYTE = 2'h3;
  localparam logic [DATA_W-1:0] RESET_VALUE = 32'h0000_0000;
  localparam logic [SHOT_W-1:0] EDGE_SHOTS = 3'h5;
  localparam logic [1:0] ALIGN_OK = 2'h0;
endpackage

//--- common/ecdm_chan_if.sv
// Interface carrying one divider's settings and modulator state.
`timescale 1ns/100ps
interface ecdm_chan_if;
  logic enable;
  logic polarity;
  logic single;
  logic burst_en;
  logic level_mode;
  logic req_level;
  logic req_rise;
  logic q_tick;
  logic [ecdm_pkg::CNT_W-1:0] count;
  logic event_start;
  logic mod_valid;
  logic mod_high;
  logic [ecdm_pkg::SHOT_W-1:0] shots_left;
  modport ctrl (
    output enable, polarity, single, burst_en, level_mode, req_level, req_rise, q_tick, count,
    input event_start, mod_valid, mod_high, shots_left
  );
  modport chan (
    input enable, polarity, single, burst_en, level_mode, req_level, req_rise, q_tick, count,
    output event_start, mod_valid, mod_high, shots_left
  );
endinterface // ecdm_chan_if

//--- rtl/ecdm_req_sync.sv
// Two-stage synchroniser and rise detector for the burst request pin.
`timescale 1ns/100ps
module ecdm_req_sync (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic pin_in,
  output logic level,
  output logic rise
);
  logic meta_reg;
  logic meta_next;
  logic sync_reg;
  logic sync_next;
  logic last_reg;
  logic last_next;

  always_comb begin
    meta_next = pin_in;
    sync_next = meta_reg;
    last_next = sync_reg;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else if (ce) begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      last_reg <= last_next;
    end
  end

  assign level = sync_reg;
  assign rise = sync_reg & ~last_reg;
endmodule // ecdm_req_sync

//--- rtl/ecdm_chan.sv
// Event sequencer of one divider's duty-cycle modulator.
`timescale 1ns/100ps
module ecdm_chan (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  ecdm_chan_if.chan ch
);
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_FIRST, ST_SECOND} ecdm_chan_state_e;
  ecdm_chan_state_e state_reg;
  ecdm_chan_state_e state_next;
  logic [ecdm_pkg::CNT_W-1:0] cnt_reg;
  logic [ecdm_pkg::CNT_W-1:0] cnt_next;
  logic [ecdm_pkg::SHOT_W-1:0] shots_reg;
  logic [ecdm_pkg::SHOT_W-1:0] shots_next;
  logic valid_reg;
  logic valid_next;
  logic high_reg;
  logic high_next;
  logic start_reg;
  logic start_next;
  logic fire_ok;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    shots_next = shots_reg;
    valid_next = valid_reg;
    high_next = high_reg;
    start_next = 1'b0;
    fire_ok = !ch.burst_en || (ch.level_mode ? ch.req_level : (shots_reg != '0));
    if (!ch.enable) begin
      state_next = ST_IDLE;
      cnt_next = '0;
      shots_next = '0;
      valid_next = 1'b0;
      high_next = 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          state_next = ST_WAIT;
          cnt_next = '0;
        end
        ST_WAIT: begin
          if (ch.q_tick) begin
            if (cnt_reg >= ch.count && fire_ok) begin
              state_next = ST_FIRST;
              cnt_next = '0;
              start_next = 1'b1;
              valid_next = 1'b1;
              high_next = ch.polarity;
              if (ch.burst_en && !ch.level_mode) begin
                shots_next = shots_reg - 1'b1;
              end
            end else if (cnt_reg != '1) begin
              cnt_next = cnt_reg + 1'b1;
            end
          end
        end
        ST_FIRST: begin
          if (ch.q_tick) begin
            if (ch.single) begin
              state_next = ST_WAIT;
              valid_next = 1'b0;
            end else begin
              state_next = ST_SECOND;
              high_next = ~ch.polarity;
            end
          end
        end
        ST_SECOND: begin
          if (ch.q_tick) begin
            state_next = ST_WAIT;
            valid_next = 1'b0;
          end
        end
      endcase
      if (ch.burst_en && !ch.level_mode && ch.req_rise) begin
        shots_next = ecdm_pkg::EDGE_SHOTS;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_reg <= ST_IDLE;
      cnt_reg <= '0;
      shots_reg <= '0;
      valid_reg <= 1'b0;
      high_reg <= 1'b0;
      start_reg <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      shots_reg <= shots_next;
      valid_reg <= valid_next;
      high_reg <= high_next;
      start_reg <= start_next;
    end
  end

  assign ch.event_start = start_reg;
  assign ch.mod_valid = valid_reg;
  assign ch.mod_high = high_reg;
  assign ch.shots_left = shots_reg;
endmodule // ecdm_chan

//--- rtl/embedded_clock_duty_modulator.sv
// Top of the embedded clock duty modulator with its Avalon-MM register slave.
//
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
// Contract
// - Events spaced by programmed Q-cycle count.
// - Feedback sync edge delayed zero to three.
// - Sync delay only used while modulating.
// - Edge request yields exactly five events.
// - Level request gives continuous events.
// - Bit two picks balanced or single pulse.
// - Bit one sets event polarity.
// - Bit zero enables; settings reset zero.
// - Sixteen-bit step in half clock cycles.
// - Request mode selects edge or level.
module embedded_clock_duty_modulator #(
  parameter int NUM_DIV = ecdm_pkg::NUM_DIV
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [ecdm_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [ecdm_pkg::DATA_W-1:0] avs_writedata,
  output logic [ecdm_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic q_cycle_tick,
  input wire logic burst_request_pin,
  output logic [ecdm_pkg::STEP_W-1:0] mod_step,
  output logic [NUM_DIV-1:0] mod_valid,
  output logic [NUM_DIV-1:0] mod_high,
  output logic fb_sync
);
  // ****************************************************************
  // Declarations.
  // ****************************************************************
  localparam int DLY_LEN = 1 << ecdm_pkg::FB_DELAY_W;

  logic [ecdm_pkg::STEP_W-1:0] step_reg;
  logic [ecdm_pkg::STEP_W-1:0] step_next;
  logic [ecdm_pkg::DATA_W-1:0] cnt_reg [ecdm_pkg::NUM_CNT];
  logic [ecdm_pkg::DATA_W-1:0] cnt_next [ecdm_pkg::NUM_CNT];
  logic [ecdm_pkg::FB_DELAY_W-1:0] feedback_sync_edge_delay_reg;
  logic [ecdm_pkg::FB_DELAY_W-1:0] feedback_sync_edge_delay_next;
  logic [ecdm_pkg::SET_W-1:0] settings_reg [NUM_DIV];
  logic [ecdm_pkg::SET_W-1:0] settings_next [NUM_DIV];
  logic req_mode_reg;
  logic req_mode_next;
  logic [ecdm_pkg::DATA_W-1:0] readdata_reg;
  logic [ecdm_pkg::DATA_W-1:0] readdata_next;
  logic waitrequest_reg;
  logic waitrequest_next;
  logic [DLY_LEN-1:0] base_hist_reg;
  logic [DLY_LEN-1:0] base_hist_next;
  logic fb_sync_reg;
  logic fb_sync_next;

  logic [ecdm_pkg::IDX_W-1:0] idx;
  logic aligned;
  logic wr_take;
  logic rd_take;
  logic [ecdm_pkg::IDX_W-1:0] cnt_off;
  logic [1:0] cnt_sel;
  logic [ecdm_pkg::CNT_BYTE_SEL_W-1:0] cnt_byte;
  logic [ecdm_pkg::BYTE_W-1:0] wr_byte;
  logic cnt_hit;
  logic req_level;
  logic req_rise;
  logic mod_on;
  logic base_edge;
  logic [ecdm_pkg::FB_DELAY_W-1:0] eff_delay;
  logic [NUM_DIV-1:0] start_vec;
  logic [NUM_DIV-1:0] valid_vec;
  logic [NUM_DIV-1:0] high_vec;
  logic [ecdm_pkg::SHOT_W-1:0] shots_vec [NUM_DIV];

  ecdm_chan_if ch_if [NUM_DIV] ();

  // ****************************************************************
  // Burst request synchroniser.
  // ****************************************************************
  ecdm_req_sync u_req_sync (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .pin_in(burst_request_pin),
    .level(req_level),
    .rise(req_rise)
  );

  // ****************************************************************
  // Divider modulators.
  // ****************************************************************
  for (genvar g = 0; g < NUM_DIV; g++) begin : g_div
    assign ch_if[g].enable = settings_reg[g][ecdm_pkg::SET_EN_BIT];
    assign ch_if[g].polarity = settings_reg[g][ecdm_pkg::SET_POL_BIT];
    assign ch_if[g].single = settings_reg[g][ecdm_pkg::SET_SINGLE_BIT];
    assign ch_if[g].burst_en = settings_reg[g][ecdm_pkg::SET_BURST_BIT];
    assign ch_if[g].level_mode = req_mode_reg;
    assign ch_if[g].req_level = req_level;
    assign ch_if[g].req_rise = req_rise;
    assign ch_if[g].q_tick = q_cycle_tick;
    assign ch_if[g].count = cnt_reg[g][ecdm_pkg::CNT_W-1:0];
    assign start_vec[g] = ch_if[g].event_start;
    assign valid_vec[g] = ch_if[g].mod_valid;
    assign high_vec[g] = ch_if[g].mod_high;
    assign shots_vec[g] = ch_if[g].shots_left;

    ecdm_chan u_chan (
      .clk(clk),
      .rst_b(rst_b),
      .ce(ce),
      .ch(ch_if[g])
    );
  end

  // ****************************************************************
  // Bus decode.
  // ****************************************************************
  always_comb begin
    idx = avs_address[ecdm_pkg::ADDR_W-1:2];
    aligned = (avs_address[1:0] == ecdm_pkg::ALIGN_OK);
    wr_take = avs_write && !waitrequest_reg && aligned;
    rd_take = avs_read && waitrequest_reg && aligned;
    cnt_off = idx - ecdm_pkg::IDX_CNT_FIRST;
    cnt_sel = cnt_off[3:2];
    cnt_byte = cnt_off[1:0];
    cnt_hit = (idx >= ecdm_pkg::IDX_CNT_FIRST) && (idx <= ecdm_pkg::IDX_CNT_LAST);
    wr_byte = avs_writedata[ecdm_pkg::BYTE_W-1:0];
    if (cnt_hit) begin
      if (cnt_byte == ecdm_pkg::CNT_TOP_BYTE) begin
        wr_byte = {{(ecdm_pkg::BYTE_W-ecdm_pkg::CNT_TOP_W){1'b0}}, avs_writedata[ecdm_pkg::CNT_TOP_W-1:0]};
      end
    end
  end

  // ****************************************************************
  // Register file next values.
  // ****************************************************************
  always_comb begin
    step_next = step_reg;
    cnt_next = cnt_reg;
    feedback_sync_edge_delay_next = feedback_sync_edge_delay_reg;
    settings_next = settings_reg;
    req_mode_next = req_mode_reg;
    if (wr_take) begin
      if (cnt_hit) begin
        cnt_next[cnt_sel][cnt_byte*ecdm_pkg::BYTE_W +: ecdm_pkg::BYTE_W] = wr_byte;
      end
      unique case (idx)
        ecdm_pkg::IDX_STEP_LO: step_next[ecdm_pkg::BYTE_W-1:0] = wr_byte;
        ecdm_pkg::IDX_STEP_HI: step_next[ecdm_pkg::STEP_W-1:ecdm_pkg::BYTE_W] = wr_byte;
        ecdm_pkg::IDX_FEEDBACK_SYNC_EDGE_DELAY: begin
          feedback_sync_edge_delay_next = avs_writedata[ecdm_pkg::FB_DELAY_W-1:0];
        end
        ecdm_pkg::IDX_DIVIDER_A_MODULATOR_SETTINGS: settings_next[0] = avs_writedata[ecdm_pkg::SET_W-1:0];
        ecdm_pkg::IDX_DIVIDER_B_MODULATOR_SETTINGS: settings_next[1] = avs_writedata[ecdm_pkg::SET_W-1:0];
        ecdm_pkg::IDX_BURST_REQUEST_MODE: req_mode_next = avs_writedata[ecdm_pkg::REQ_MODE_BIT];
        default: begin
        end
      endcase
    end
  end

  // ****************************************************************
  // Read data and wait request.
  // ****************************************************************
  always_comb begin
    readdata_next = readdata_reg;
    waitrequest_next = ~((avs_read || avs_write) && waitrequest_reg);
    if (rd_take) begin
      readdata_next = ecdm_pkg::RESET_VALUE;
      if (cnt_hit) begin
        readdata_next[ecdm_pkg::BYTE_W-1:0] = cnt_reg[cnt_sel][cnt_byte*ecdm_pkg::BYTE_W +: ecdm_pkg::BYTE_W];
      end
      unique case (idx)
        ecdm_pkg::IDX_STEP_LO: readdata_next[ecdm_pkg::BYTE_W-1:0] = step_reg[ecdm_pkg::BYTE_W-1:0];
        ecdm_pkg::IDX_STEP_HI: begin
          readdata_next[ecdm_pkg::BYTE_W-1:0] = step_reg[ecdm_pkg::STEP_W-1:ecdm_pkg::BYTE_W];
        end
        ecdm_pkg::IDX_FEEDBACK_SYNC_EDGE_DELAY: begin
          readdata_next[ecdm_pkg::FB_DELAY_W-1:0] = feedback_sync_edge_delay_reg;
        end
        ecdm_pkg::IDX_DIVIDER_A_MODULATOR_SETTINGS: readdata_next[ecdm_pkg::SET_W-1:0] = settings_reg[0];
        ecdm_pkg::IDX_DIVIDER_B_MODULATOR_SETTINGS: readdata_next[ecdm_pkg::SET_W-1:0] = settings_reg[1];
        ecdm_pkg::IDX_BURST_REQUEST_MODE: readdata_next[ecdm_pkg::REQ_MODE_BIT] = req_mode_reg;
        ecdm_pkg::IDX_MODULATOR_STATUS: begin
          readdata_next[ecdm_pkg::ST_VALID_LSB +: NUM_DIV] = valid_vec;
          readdata_next[ecdm_pkg::ST_MOD_ON_BIT] = mod_on;
          readdata_next[ecdm_pkg::ST_REQ_BIT] = req_level;
          readdata_next[ecdm_pkg::ST_SHOTS_A_LSB +: ecdm_pkg::SHOT_W] = shots_vec[0];
          readdata_next[ecdm_pkg::ST_SHOTS_B_LSB +: ecdm_pkg::SHOT_W] = shots_vec[1];
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************************************
  // Feedback sync edge delay.
  // ****************************************************************
  always_comb begin
    mod_on = 1'b0;
    for (int i = 0; i < NUM_DIV; i++) begin
      mod_on = mod_on | settings_reg[i][ecdm_pkg::SET_EN_BIT];
    end
    base_edge = |start_vec;
    eff_delay = mod_on ? feedback_sync_edge_delay_reg : '0;
    base_hist_next = {base_hist_reg[DLY_LEN-2:0], base_edge};
    fb_sync_next = mod_on && base_hist_reg[eff_delay];
  end

  // ****************************************************************
  // State registers.
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      step_reg <= '0;
      for (int i = 0; i < ecdm_pkg::NUM_CNT; i++) begin
        cnt_reg[i] <= ecdm_pkg::RESET_VALUE;
      end
      feedback_sync_edge_delay_reg <= '0;
      for (int i = 0; i < NUM_DIV; i++) begin
        settings_reg[i] <= '0;
      end
      req_mode_reg <= 1'b0;
      readdata_reg <= ecdm_pkg::RESET_VALUE;
      waitrequest_reg <= 1'b1;
      base_hist_reg <= '0;
      fb_sync_reg <= 1'b0;
    end else if (ce) begin
      step_reg <= step_next;
      cnt_reg <= cnt_next;
      feedback_sync_edge_delay_reg <= feedback_sync_edge_delay_next;
      settings_reg <= settings_next;
      req_mode_reg <= req_mode_next;
      readdata_reg <= readdata_next;
      waitrequest_reg <= waitrequest_next;
      base_hist_reg <= base_hist_next;
      fb_sync_reg <= fb_sync_next;
    end
  end

  // ****************************************************************
  // Outputs.
  // ****************************************************************
  assign avs_readdata = readdata_reg;
  assign avs_waitrequest = waitrequest_reg;
  assign mod_step = step_reg;
  assign mod_valid = valid_vec;
  assign mod_high = high_vec;
  assign fb_sync = fb_sync_reg;
endmodule // embedded_clock_duty_modulator

//--- testbench/ecdm_properties.sv
// Checker with the port properties of the duty modulator.
`timescale 1ns/100ps
module ecdm_properties #(
  parameter int NUM_DIV = 2
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [ecdm_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [ecdm_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [ecdm_pkg::DATA_W-1:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic q_cycle_tick,
  input wire logic burst_request_pin,
  input wire logic [ecdm_pkg::STEP_W-1:0] mod_step,
  input wire logic [NUM_DIV-1:0] mod_valid,
  input wire logic [NUM_DIV-1:0] mod_high,
  input wire logic fb_sync
);
  // ****************************************************************
  // Properties.
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  wait_one_cycle_a: assert property (ce && !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  answer_after_req_a: assert property (ce && avs_waitrequest && (avs_read || avs_write) |=> !avs_waitrequest)
    else $error("request not answered after one wait cycle");
  readdata_holds_a: assert property ($changed(avs_readdata) |-> $past(avs_read))
    else $error("read data changed without a read");
  step_by_write_a: assert property ($changed(mod_step) |-> $past(avs_write) || $past(avs_write, 2))
    else $error("step output changed without a write");
  start_on_tick_a: assert property ($rose(mod_valid[0]) |-> $past(q_cycle_tick))
    else $error("event on divider a started away from a tick");
  start_b_tick_a: assert property ($rose(mod_valid[1]) |-> $past(q_cycle_tick))
    else $error("event on divider b started away from a tick");
  end_on_tick_a: assert property ($fell(mod_valid[0]) |-> $past(q_cycle_tick) || $past(avs_write) || $past(avs_write, 2))
    else $error("event on divider a ended away from a tick");
  flip_on_tick_a: assert property (mod_valid[0] && $past(mod_valid[0]) && $changed(mod_high[0]) |-> $past(q_cycle_tick))
    else $error("event direction changed away from a tick");
  sync_follows_a: assert property ($rose(|mod_valid) |-> ##[2:5] fb_sync)
    else $error("sync edge missing after event start");
  sync_when_mod_a: assert property (fb_sync |-> $past(|mod_valid))
    else $error("sync edge without modulation");
  sync_pulse_a: assert property (fb_sync |=> !fb_sync)
    else $error("sync edge longer than one cycle");
  cover property ($rose(mod_valid[0]));
  cover property (mod_valid[0] && mod_high[0]);
  cover property (fb_sync);
endmodule // ecdm_properties

bind embedded_clock_duty_modulator ecdm_properties #(.NUM_DIV(NUM_DIV)) i_props (
  .clk(clk), .rst_b(rst_b), .ce(ce), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .q_cycle_tick(q_cycle_tick), .burst_request_pin(burst_request_pin), .mod_step(mod_step),
  .mod_valid(mod_valid), .mod_high(mod_high), .fb_sync(fb_sync)
);

//--- testbench/ecdm_consumer.sv
// Model of the clock consumer that makes Q-cycle ticks and counts events.
`timescale 1ns/100ps
module ecdm_consumer #(
  parameter int TICK = 6
) (
  input wire logic clk,
  input wire logic rst_b,
  output logic q_cycle_tick,
  input wire logic [1:0] mod_valid,
  input wire logic fb_sync,
  output logic [15:0] ev_a,
  output logic [15:0] ev_b,
  output logic [15:0] n_sync
);
  int cnt;
  logic [1:0] valid_q;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cnt <= 0;
      q_cycle_tick <= 1'b0;
      valid_q <= 2'h0;
      ev_a <= 16'h0;
      ev_b <= 16'h0;
      n_sync <= 16'h0;
    end else begin
      cnt <= (cnt == TICK - 1) ? 0 : cnt + 1;
      q_cycle_tick <= (cnt == TICK - 1);
      valid_q <= mod_valid;
      ev_a <= ev_a + 16'(mod_valid[0] && !valid_q[0]);
      ev_b <= ev_b + 16'(mod_valid[1] && !valid_q[1]);
      n_sync <= n_sync + 16'(fb_sync);
    end
  end
endmodule // ecdm_consumer

//--- testbench/embedded_clock_duty_modulator_tb.sv
// Self-checking bench of the embedded clock duty modulator.
`timescale 1ns/100ps
module embedded_clock_duty_modulator_tb;
  localparam int P = 6;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic [14:0] avs_address = 15'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic q_cycle_tick;
  logic burst_request_pin = 1'b0;
  logic [15:0] mod_step;
  logic [1:0] mod_valid;
  logic [1:0] mod_high;
  logic fb_sync;
  logic [15:0] ev_a;
  logic [15:0] ev_b;
  logic [15:0] n_sync;
  logic [15:0] e0;
  logic [31:0] rd;
  logic hf;
  logic hl;
  int n_fail = 0;
  int total_checks = 0;
  int cycles = 0;
  int gap;
  int len;
  int fbd;
  int g0;
  logic [12:0] idx_a;
  logic [12:0] idx_top;
  always #25 clk = ~clk;
  embedded_clock_duty_modulator i_dut (
    .clk(clk), .rst_b(rst_b), .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .q_cycle_tick(q_cycle_tick), .burst_request_pin(burst_request_pin),
    .mod_step(mod_step), .mod_valid(mod_valid), .mod_high(mod_high), .fb_sync(fb_sync)
  );
  ecdm_consumer #(.TICK(P)) i_cons (
    .clk(clk), .rst_b(rst_b), .q_cycle_tick(q_cycle_tick), .mod_valid(mod_valid), .fb_sync(fb_sync),
    .ev_a(ev_a), .ev_b(ev_b), .n_sync(n_sync)
  );
  // ****************************************************************
  // Tasks.
  // ****************************************************************
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [12:0] idx, input logic [31:0] d);
    avs_address <= {idx, 2'h0};
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic measure(input int i);
    while (mod_valid[i] === 1'b1) @(posedge clk);
    gap = 0;
    while (mod_valid[i] !== 1'b1) begin
      @(posedge clk);
      gap++;
    end
    len = 0;
    fbd = 99;
    hf = mod_high[i];
    while (mod_valid[i] === 1'b1) begin
      if (fb_sync === 1'b1 && fbd == 99) fbd = len;
      hl = mod_high[i];
      @(posedge clk);
      len++;
    end
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      n_fail++;
      complete_run();
    end
  end
  // ****************************************************************
  // Tests.
  // ****************************************************************
  initial begin
    idx_a = ecdm_pkg::IDX_DIVIDER_A_MODULATOR_SETTINGS;
    idx_top = ecdm_pkg::IDX_DIVIDER_C_EVENT_COUNT_TOP;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, idx_top + 13'(i), 32'h0);
      check("reset value", rd, 32'h0);
    end
    $display("reset values done");
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, idx_top + 13'(i), 32'hFF);
      bus(1'b0, idx_top + 13'(i), 32'h0);
      check("register mask", rd, (i == 1) ? 32'h3 : 32'hF);
      bus(1'b1, idx_top + 13'(i), 32'h0);
    end
    bus(1'b1, 13'h10D5, 32'hFF);
    bus(1'b0, 13'h10D5, 32'h0);
    check("unmapped read", rd, 32'h0);
    bus(1'b1, ecdm_pkg::IDX_STEP_LO, 32'h34);
    bus(1'b1, ecdm_pkg::IDX_STEP_HI, 32'h12);
    check("step", 32'(mod_step), 32'h1234);
    $display("register test done");
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, idx_a, 32'(1 + 2 * m));
      measure(0);
      measure(0);
      check("event length", len, (m > 1) ? P : 2 * P);
      check("first half", 32'(hf), 32'(m % 2));
      check("second half", 32'(hl), (m > 1) ? 32'(m % 2) : 32'(1 - m % 2));
    end
    bus(1'b1, idx_a, 32'h0);
    bus(1'b1, ecdm_pkg::IDX_DIVIDER_B_MODULATOR_SETTINGS, 32'h3);
    e0 = ev_a;
    measure(1);
    measure(1);
    check("divider b length", len, 2 * P);
    check("divider b first half", 32'(hf), 32'h1);
    check("divider a idle", 32'(ev_a), 32'(e0));
    bus(1'b1, ecdm_pkg::IDX_DIVIDER_B_MODULATOR_SETTINGS, 32'h0);
    $display("mode test done");
    bus(1'b1, idx_a, 32'h1);
    measure(0);
    measure(0);
    g0 = gap;
    bus(1'b1, ecdm_pkg::IDX_CNT_FIRST, 32'h3);
    measure(0);
    measure(0);
    check("event spacing", gap, g0 + 3 * P);
    bus(1'b1, ecdm_pkg::IDX_CNT_FIRST, 32'h0);
    measure(0);
    e0 = ev_a;
    ce <= 1'b0;
    repeat (60) @(posedge clk);
    check("clock enable hold", 32'(ev_a), 32'(e0));
    ce <= 1'b1;
    for (int d = 0; d < 4; d++) begin
      bus(1'b1, ecdm_pkg::IDX_FEEDBACK_SYNC_EDGE_DELAY, 32'(d));
      measure(0);
      measure(0);
      if (d == 0) g0 = fbd;
      check("sync delay", fbd, g0 + d);
    end
    bus(1'b1, idx_a, 32'h0);
    repeat (30) @(posedge clk);
    e0 = n_sync;
    repeat (100) @(posedge clk);
    check("sync while off", 32'(n_sync), 32'(e0));
    $display("timing test done");
    bus(1'b1, ecdm_pkg::IDX_BURST_REQUEST_MODE, 32'h0);
    bus(1'b1, idx_a, 32'h9);
    e0 = ev_a;
    repeat (100) @(posedge clk);
    check("no request", 32'(ev_a - e0), 32'h0);
    burst_request_pin <= 1'b1;
    repeat (500) @(posedge clk);
    check("edge burst", 32'(ev_a - e0), 32'h5);
    bus(1'b0, ecdm_pkg::IDX_MODULATOR_STATUS, 32'h0);
    check("status", rd, 32'hC);
    burst_request_pin <= 1'b0;
    bus(1'b1, ecdm_pkg::IDX_BURST_REQUEST_MODE, 32'h40);
    e0 = ev_a;
    burst_request_pin <= 1'b1;
    repeat (300) @(posedge clk);
    check("level burst", 32'(ev_a - e0 > 16'h5), 32'h1);
    burst_request_pin <= 1'b0;
    repeat (40) @(posedge clk);
    e0 = ev_a;
    repeat (200) @(posedge clk);
    check("level stop", 32'(ev_a), 32'(e0));
    $display("burst test done");
    complete_run();
  end
endmodule // embedded_clock_duty_modulator_tb
